// ===== rtl/gpl_pkg.sv
// shared constants and carrier types for the gpio port
package gpl_pkg;
  localparam int GPL_WIDTH = 8;
  localparam logic [7:0] GPL_LATCH_RST = 8'h00;
  localparam logic [7:0] GPL_DIR_RST = 8'h00;
  localparam logic [7:0] GPL_PULL_RST = 8'h00;
  localparam logic [1:0] GPL_SEL_DATA = 2'h0;
  localparam logic [1:0] GPL_SEL_DIR = 2'h1;
  localparam logic [1:0] GPL_SEL_PULL = 2'h2;
  localparam logic [7:0] GPL_DIR_READ_VAL = 8'h00;
  localparam logic [7:0] GPL_RDATA_RST = 8'h00;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_en;
  } gpl_pad_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] sel;
    logic [7:0] wdata;
  } gpl_cpu_t;
endpackage : gpl_pkg

// ===== rtl/gpl_port.sv
// 8-bit port with output latch, write-only direction and input-only pull-ups
module gpl_port
  import gpl_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire gpl_pkg::gpl_cpu_t CPU,
  output logic [7:0] RDATA,
  input wire logic STANDBY,
  input wire logic [7:0] PIN_IN,
  output gpl_pkg::gpl_pad_t PAD
);
  import gpl_pkg::*;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int W = GPL_WIDTH;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0] latch_q;
  logic [7:0] latch_d;
  logic [7:0] dir_q;
  logic [7:0] dir_d;
  logic [7:0] pull_q;
  logic [7:0] pull_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] pin_s;

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  // pins are asynchronous to the cpu clock
  gpl_sync #(
    .WIDTH(W)
  ) u_sync (
    .CLK(CLK),
    .RESETN(RESETN),
    .D(PIN_IN),
    .Q(pin_s)
  );

  // ----------------------------------------
  // selector decode
  // ----------------------------------------
  // true when the bus selector names the given target
  function automatic logic sel_hit(input logic [1:0] sel, input logic [1:0] code);
    return sel == code;
  endfunction

  logic hit_data;
  logic hit_dir;
  logic hit_pull;
  logic wr_data;
  logic wr_dir;
  logic wr_pull;
  logic rd_strobe;

  assign hit_data = sel_hit(CPU.sel, GPL_SEL_DATA);
  assign hit_dir = sel_hit(CPU.sel, GPL_SEL_DIR);
  assign hit_pull = sel_hit(CPU.sel, GPL_SEL_PULL);

  // the unmapped selector matches none of these, so its writes are dropped
  assign wr_data = CPU.wr && hit_data;
  assign wr_dir = CPU.wr && hit_dir;
  assign wr_pull = CPU.wr && hit_pull;
  assign rd_strobe = CPU.rd;

  // ----------------------------------------
  // per-bit datapath
  // ----------------------------------------
  logic [W-1:0] port_view;
  logic [W-1:0] oe_bit;
  logic [W-1:0] pull_bit;

  for (genvar b = 0; b < W; b++) begin : g_bit
    // outputs show their latch, inputs their synchronised pin
    assign port_view[b] = dir_q[b] ? latch_q[b] : pin_s[b];
    // driver on only for outputs and never in stand-by
    assign oe_bit[b] = dir_q[b] & ~STANDBY;
    // pull-up control counts only while the bit is an input
    assign pull_bit[b] = pull_q[b] & ~dir_q[b];
  end

  // ----------------------------------------
  // read selection
  // ----------------------------------------
  logic [7:0] rd_mux;

  // direction and unmapped reads give a fixed value, never the setting
  assign rd_mux = hit_data ? port_view :
                  hit_pull ? pull_q :
                  GPL_DIR_READ_VAL;

  // ----------------------------------------
  // next values
  // ----------------------------------------
  // direction writes never touch the latch
  assign latch_d = wr_data ? CPU.wdata : latch_q;
  assign dir_d = wr_dir ? CPU.wdata : dir_q;
  assign pull_d = wr_pull ? CPU.wdata : pull_q;
  assign rdata_d = rd_strobe ? rd_mux : rdata_q;

  // ----------------------------------------
  // output latch
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      latch_q <= GPL_LATCH_RST;
    end else begin
      latch_q <= latch_d;
    end
  end

  // ----------------------------------------
  // direction register
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      dir_q <= GPL_DIR_RST;
    end else begin
      dir_q <= dir_d;
    end
  end

  // ----------------------------------------
  // pull-up control register
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      pull_q <= GPL_PULL_RST;
    end else begin
      pull_q <= pull_d;
    end
  end

  // ----------------------------------------
  // read data register
  // ----------------------------------------
  // holds the last read until the next read strobe
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      rdata_q <= GPL_RDATA_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // pad drive
  // ----------------------------------------
  assign PAD.out = latch_q;
  assign PAD.oe = oe_bit;
  assign PAD.pull_en = pull_bit;
  assign RDATA = rdata_q;
endmodule // gpl_port

// ===== rtl/gpl_sync.sv
// two-stage synchroniser for the pin levels
module gpl_sync #(
  parameter int WIDTH = 8
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [WIDTH-1:0] D,
  output logic [WIDTH-1:0] Q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      meta_q <= '0;
      Q <= '0;
    end else begin
      meta_q <= D;
      Q <= meta_q;
    end
  end
endmodule // gpl_sync

// ===== test/gpl_board.sv
// board model driving the port pins
module gpl_board import gpl_pkg::*; (input wire gpl_pad_t PAD, input wire logic [7:0] EXT_LVL, output logic [7:0] PIN_IN);
  assign PIN_IN = PAD.oe & PAD.out | ~PAD.oe & EXT_LVL;
endmodule // gpl_board

// ===== test/gpl_chk.sv
// port checker
module gpl_chk import gpl_pkg::*; (input wire logic CLK, RESETN, STANDBY, input wire gpl_cpu_t CPU,
  input wire logic [7:0] RDATA, input wire gpl_pad_t PAD);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  a_sb_off: assert property (STANDBY |-> !PAD.oe) else $error("oe");
  a_pu_in: assert property (!(PAD.pull_en & PAD.oe)) else $error("pu");
  a_wr_lt: assert property (CPU.wr && !CPU.sel |=> PAD.out == $past(CPU.wdata)) else $error("wr");
  a_dir_wo: assert property (CPU.rd && CPU.sel == GPL_SEL_DIR |=> !RDATA) else $error("dir");
  a_dir_keep: assert property (CPU.wr && CPU.sel == GPL_SEL_DIR |=> $stable(PAD.out)) else $error("keep");
  a_rst_in: assert property (disable iff (1'b0) !RESETN |=> PAD.oe == 8'h00 && PAD.pull_en == 8'h00)
    else $error("rst");
endmodule // gpl_chk
bind gpl_port gpl_chk gpl_chk_inst (.*);

// ===== test/testbench.sv
// gpio port bench
module testbench;
  timeunit 1ns / 1ns;
  import gpl_pkg::*;
  logic CLK = 0, RESETN = 0, STANDBY = 0;
  logic [7:0] RDATA, PIN_IN, EXT_LVL = 8'hA5;
  int mismatches = 0, cmp_count = 0;
  gpl_cpu_t CPU = '0;
  gpl_pad_t PAD;
  logic [17:0] rows [4] = '{18'h100A5, 18'h03CA5, 18'h1F035, 18'h100A5};
  gpl_port gpl_port_inst (.*);
  gpl_board gpl_board_inst (.*);
  initial forever #10 CLK = ~CLK;
  task automatic acc(logic w, logic [1:0] s, logic [7:0] d);
    CPU = {!w, w, s, d};
    @(negedge CLK) CPU = '0;
  endtask
  task automatic chk(logic [7:0] g, e);
    cmp_count++;
    if (g !== e) $display("CHECK FAILED %0t %h %h", $time, g, e);
    mismatches += int'(g !== e);
  endtask
  task automatic stop_test(int late);
    mismatches += late;
    $display("mismatches %0d checks %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial #9000 stop_test(1);
  initial begin
    repeat (20) @(negedge CLK);
    RESETN = 1;
    chk(PAD.oe, 0);
    foreach (rows[i]) begin
      acc(1, rows[i][17:16], rows[i][15:8]);
      repeat (3) @(negedge CLK);
      acc(0, 0, 0);
      chk(RDATA, rows[i][7:0]);
    end
    chk(PAD.out, 8'h3C);
    acc(0, 1, 0);
    chk(RDATA, 0);
    acc(1, 1, 8'hF0);
    acc(1, 2, 8'hFF);
    chk(PAD.pull_en, 8'h0F);
    acc(0, 0, 0);
    acc(1, 0, RDATA | 8'h80);
    chk(PAD.out, 8'hB5);
    chk(PAD.oe, 8'hF0);
    STANDBY = 1;
    #1 chk(PAD.oe, 0);
    @(negedge CLK) STANDBY = 0;
    acc(1, 3, 8'hFF);
    chk(PAD.out, 8'hB5);
    acc(0, 3, 0);
    chk(RDATA, 8'h00);
    chk(PAD.oe, 8'hF0);
    RESETN = 0;
    repeat (2) @(negedge CLK);
    RESETN = 1;
    chk(PAD.oe, 8'h00);
    chk(PAD.out, 8'h00);
    chk(RDATA, 8'h00);
    stop_test(0);
  end
endmodule // testbench
